// >>> ddr2_timing_pkg.sv
// Timing constants, commands and pin bundles for the DDR2 command sequencer
package ddr2_timing_pkg;
  // Clock and printed memory timings
  localparam int T_CK_PS = 50000;
  localparam int T_RRD_PS = 7500;
  localparam int T_WR_PS = 15000;
  localparam int T_RP_PS = 15000;
  localparam int T_WTR_PS = 7500;
  localparam int T_RTP_PS = 7500;
  localparam int T_RFC_PS = 127500;
  localparam int T_XSNR_ADD_PS = 10000;
  localparam int T_IS_PS = 200;
  localparam int T_IH_PS = 275;
  localparam int T_REFI_COOL_PS = 7800000;
  localparam int T_REFI_HOT_PS = 3900000;

  // Least times round up, longest round down, never below one cycle
  function automatic int cyc_up(input int ps);
    return ((ps + T_CK_PS - 1) / T_CK_PS < 1) ? 1 : (ps + T_CK_PS - 1) / T_CK_PS;
  endfunction
  function automatic int cyc_dn(input int ps);
    return (ps / T_CK_PS < 1) ? 1 : ps / T_CK_PS;
  endfunction

  // Cycle counts
  localparam logic [7:0] MRD_CYC = 8'h02;
  localparam logic [7:0] RRD_CYC = 8'(cyc_up(T_RRD_PS));
  localparam logic [7:0] WR_CYC = 8'(cyc_up(T_WR_PS));
  localparam logic [7:0] RP_CYC = 8'(cyc_up(T_RP_PS));
  localparam logic [7:0] WTR_CYC = 8'(cyc_up(T_WTR_PS));
  localparam logic [7:0] RTP_CYC = 8'(cyc_up(T_RTP_PS));
  localparam logic [7:0] RFC_CYC = 8'(cyc_up(T_RFC_PS));
  localparam logic [7:0] XSNR_CYC = 8'(cyc_up(T_RFC_PS + T_XSNR_ADD_PS));
  localparam logic [7:0] XSRD_CYC = 8'hc8;
  localparam logic [7:0] XP_CYC = 8'h02;
  localparam logic [7:0] XARD_CYC = 8'h02;
  localparam logic [7:0] XARDS_SLOW_CYC = 8'h07;
  localparam logic [7:0] XARDS_FAST_CYC = 8'h08;
  localparam logic [7:0] CKE_CYC = 8'h03;
  localparam logic [7:0] ANPD_CYC = 8'h03;
  localparam logic [7:0] AXPD_CYC = 8'h08;
  localparam logic [7:0] DLY_CYC = 8'(cyc_up(T_IS_PS + T_CK_PS + T_IH_PS));
  localparam logic [7:0] REFI_COOL_CYC = 8'(cyc_dn(T_REFI_COOL_PS));
  localparam logic [7:0] REFI_HOT_CYC = 8'(cyc_dn(T_REFI_HOT_PS));

  // Command pin codes {cs_n, ras_n, cas_n, we_n} and auto-precharge bit
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam int AP_BIT = 10;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_MRS = 4'h1, OP_ACT = 4'h2, OP_RD = 4'h3,
    OP_WR = 4'h4, OP_WRA = 4'h5, OP_PRE = 4'h6, OP_PREA = 4'h7,
    OP_REF = 4'h8, OP_SRE = 4'h9, OP_SRX = 4'ha, OP_PDE = 4'hb,
    OP_PDX = 4'hc
  } op_e;

  typedef enum logic [1:0] {ST_NORM = 2'b00, ST_PD = 2'b01, ST_SR = 2'b10} mst_e;

  typedef struct packed {
    op_e op;
    logic [2:0] bank;
    logic [13:0] addr;
  } req_s;

  typedef struct packed {
    logic cke;
    logic [3:0] cmd;
    logic [2:0] ba;
    logic [13:0] addr;
    logic odt;
  } pins_s;
endpackage

// >>> ddr2_cmd_timer.sv
`timescale 1ns/1ps
// Host-side DDR2 command sequencer that spaces commands to the memory
// Functional notes
// - After mode register set, wait 2 cycles before next command.
// - Activates to different banks spaced by 7.5 ns in cycles.
// - Write recovery 15 ns before precharge; programmed count is tWR over tCK.
// - After write with auto-precharge, wait recovery plus precharge before activate.
// - Allow 7.5 ns from write burst end to a read.
// - Read to precharge of that bank at least 7.5 ns.
// - After self-refresh exit, wait refresh time plus 10 ns for non-reads.
// - After self-refresh exit, wait 200 cycles before a read.
// - After precharge power-down exit, wait 2 cycles for non-reads.
// - Active power-down exit to read: 2 fast, 7 or 8 minus latency slow.
// - Hold each clock-enable level at least 3 cycles.
// - After refresh, wait 127.5 ns before activate or refresh.
// - Refresh on average every 7.8 us, or 3.9 us when hot.
// - Termination control settled 3 cycles before power-down entry.
// - After power-down exit, 8 cycles before synchronous termination control.
// - First write strobe within a quarter cycle of write latency position.
// - Keep memory clock running setup plus period plus hold after clock-enable drop.
module ddr2_cmd_timer #(
  parameter int WL = 2,
  parameter int BL = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // User command request
  input wire logic req_valid,
  input wire ddr2_timing_pkg::req_s req,
  output logic req_ready,
  // User options and status
  input wire logic odt_req,
  input wire logic hot_temp,
  input wire logic slow_exit,
  input wire logic fast_grade,
  input wire logic [2:0] add_lat,
  output logic ref_busy,
  output logic [7:0] mr_wr_cyc,
  // Memory pins
  output ddr2_timing_pkg::pins_s mem,
  output logic ck_en,
  output logic dqs_en,
  output logic dqs_oe_n
);
  localparam int WSH_W = WL + BL / 2 - 1;
  localparam logic [7:0] BURST_END = 8'(WL + BL / 2);
  localparam logic [7:0] WR_TO_RD = BURST_END + ddr2_timing_pkg::WTR_CYC - 8'h01;
  localparam logic [7:0] WR_TO_PRE = BURST_END + ddr2_timing_pkg::WR_CYC - 8'h01;
  localparam logic [7:0] DAL_LD = BURST_END + ddr2_timing_pkg::WR_CYC
                                  + ddr2_timing_pkg::RP_CYC - 8'h01;

  // Keep the larger of a running count and a new load
  function automatic logic [7:0] ld(input logic [7:0] cur, input logic [7:0] val);
    return (cur > val) ? cur : val;
  endfunction

  ddr2_timing_pkg::mst_e st_reg, st_next;
  ddr2_timing_pkg::op_e iss_op, int_op, lop_reg;
  ddr2_timing_pkg::pins_s mem_reg, mem_next;
  logic [7:0] nrd_reg, nrd_next, rd_reg, rd_next, rrd_reg, rrd_next;
  logic [7:0] rfc_reg, rfc_next, pre_reg, pre_next, axpd_reg, axpd_next;
  logic [7:0] cke_cnt_reg, cke_cnt_next, odt_cnt_reg, odt_cnt_next;
  logic [7:0] refi_reg, refi_next;
  logic [7:0] bank_reg [8];
  logic [7:0] open_reg, open_next;
  logic ref_pend_reg, pd_act_reg, ck_en_reg, dqs_en_reg;
  logic [WSH_W-1:0] wsh_reg;
  logic [15:0] ok_vec;

  // Legality of each command in the present cycle
  wire logic norm = (st_reg == ddr2_timing_pkg::ST_NORM);
  wire logic nrd0 = (nrd_reg == 8'h00);
  wire logic cke_ok = (cke_cnt_reg >= ddr2_timing_pkg::CKE_CYC - 8'h01);
  wire logic odt_ok = (odt_cnt_reg >= ddr2_timing_pkg::ANPD_CYC - 8'h01);
  wire logic ub_open = open_reg[req.bank];
  wire logic idle = (open_reg == 8'h00);
  wire logic ref_ok = norm && nrd0 && (rfc_reg == 8'h00) && idle;
  assign ok_vec[0] = 1'b1;
  assign ok_vec[1] = norm && nrd0 && idle;
  assign ok_vec[2] = norm && nrd0 && (rrd_reg == 8'h00) && (rfc_reg == 8'h00)
                     && (bank_reg[req.bank] == 8'h00) && !ub_open;
  assign ok_vec[3] = norm && (rd_reg == 8'h00) && ub_open;
  assign ok_vec[4] = norm && nrd0 && ub_open;
  assign ok_vec[5] = norm && nrd0 && ub_open;
  assign ok_vec[6] = norm && nrd0 && (pre_reg == 8'h00);
  assign ok_vec[7] = norm && nrd0 && (pre_reg == 8'h00);
  assign ok_vec[8] = ref_ok;
  assign ok_vec[9] = ref_ok && cke_ok && odt_ok;
  assign ok_vec[10] = (st_reg == ddr2_timing_pkg::ST_SR) && cke_ok && ck_en_reg;
  assign ok_vec[11] = norm && nrd0 && cke_ok && odt_ok;
  assign ok_vec[12] = (st_reg == ddr2_timing_pkg::ST_PD) && cke_ok;
  assign ok_vec[15:13] = 3'h0;

  // Refresh takes the bus: wake from power-down, close banks, then refresh
  assign int_op = (st_reg == ddr2_timing_pkg::ST_PD) ? ddr2_timing_pkg::OP_PDX :
                  !idle ? ddr2_timing_pkg::OP_PREA : ddr2_timing_pkg::OP_REF;
  wire logic int_go = ref_pend_reg && ok_vec[int_op];
  assign req_ready = !ref_pend_reg && ok_vec[req.op];
  wire logic user_go = req_valid && req_ready;
  assign iss_op = int_go ? int_op : user_go ? req.op : ddr2_timing_pkg::OP_NOP;
  wire logic is_wr = (iss_op == ddr2_timing_pkg::OP_WR) || (iss_op == ddr2_timing_pkg::OP_WRA);

  // Slow-exit read wait depends on grade and additive latency
  wire logic [7:0] xards_base = fast_grade ? ddr2_timing_pkg::XARDS_FAST_CYC
                                           : ddr2_timing_pkg::XARDS_SLOW_CYC;
  wire logic [7:0] xards = (xards_base > {5'h00, add_lat}) ?
                           xards_base - {5'h00, add_lat} : 8'h01;
  wire logic [7:0] refi_lim = hot_temp ? ddr2_timing_pkg::REFI_HOT_CYC
                                       : ddr2_timing_pkg::REFI_COOL_CYC;
  // A tick at self-refresh entry would leave the flag stuck inside self refresh
  wire logic refi_fire = (st_reg != ddr2_timing_pkg::ST_SR)
                         && (iss_op != ddr2_timing_pkg::OP_SRE)
                         && (refi_reg >= refi_lim - 8'h01);
  wire logic odt_chg = (odt_req != mem_reg.odt) && (axpd_reg == 8'h00) && norm
                       && (iss_op != ddr2_timing_pkg::OP_PDE)
                       && (iss_op != ddr2_timing_pkg::OP_SRE);

  // Pin values for the chosen command
  always_comb begin
    mem_next = mem_reg;
    mem_next.cmd = ddr2_timing_pkg::CMD_NOP;
    mem_next.ba = req.bank;
    mem_next.addr = req.addr;
    mem_next.odt = odt_chg ? odt_req : mem_reg.odt;
    case (iss_op)
      ddr2_timing_pkg::OP_MRS: mem_next.cmd = ddr2_timing_pkg::CMD_MRS;
      ddr2_timing_pkg::OP_ACT: mem_next.cmd = ddr2_timing_pkg::CMD_ACT;
      ddr2_timing_pkg::OP_RD: begin
        mem_next.cmd = ddr2_timing_pkg::CMD_RD;
        mem_next.addr[ddr2_timing_pkg::AP_BIT] = 1'b0;
      end
      ddr2_timing_pkg::OP_WR: begin
        mem_next.cmd = ddr2_timing_pkg::CMD_WR;
        mem_next.addr[ddr2_timing_pkg::AP_BIT] = 1'b0;
      end
      ddr2_timing_pkg::OP_WRA: begin
        mem_next.cmd = ddr2_timing_pkg::CMD_WR;
        mem_next.addr[ddr2_timing_pkg::AP_BIT] = 1'b1;
      end
      ddr2_timing_pkg::OP_PRE: begin
        mem_next.cmd = ddr2_timing_pkg::CMD_PRE;
        mem_next.addr[ddr2_timing_pkg::AP_BIT] = 1'b0;
      end
      ddr2_timing_pkg::OP_PREA: begin
        mem_next.cmd = ddr2_timing_pkg::CMD_PRE;
        mem_next.addr[ddr2_timing_pkg::AP_BIT] = 1'b1;
      end
      ddr2_timing_pkg::OP_REF: mem_next.cmd = ddr2_timing_pkg::CMD_REF;
      ddr2_timing_pkg::OP_SRE: begin
        mem_next.cmd = ddr2_timing_pkg::CMD_REF;
        mem_next.cke = 1'b0;
      end
      ddr2_timing_pkg::OP_PDE: mem_next.cke = 1'b0;
      ddr2_timing_pkg::OP_SRX, ddr2_timing_pkg::OP_PDX: mem_next.cke = 1'b1;
      default: mem_next.cmd = ddr2_timing_pkg::CMD_NOP;
    endcase
  end

  // Mode and open-bank tracking
  always_comb begin
    st_next = st_reg;
    open_next = open_reg;
    case (iss_op)
      ddr2_timing_pkg::OP_SRE: st_next = ddr2_timing_pkg::ST_SR;
      ddr2_timing_pkg::OP_PDE: st_next = ddr2_timing_pkg::ST_PD;
      ddr2_timing_pkg::OP_SRX, ddr2_timing_pkg::OP_PDX: st_next = ddr2_timing_pkg::ST_NORM;
      ddr2_timing_pkg::OP_ACT: open_next[req.bank] = 1'b1;
      ddr2_timing_pkg::OP_PRE, ddr2_timing_pkg::OP_WRA: open_next[req.bank] = 1'b0;
      ddr2_timing_pkg::OP_PREA: open_next = 8'h00;
      default: st_next = st_reg;
    endcase
  end

  // Spacing counters; each counts down to zero and loads on its command
  always_comb begin
    nrd_next = (nrd_reg != 8'h00) ? nrd_reg - 8'h01 : 8'h00;
    rd_next = (rd_reg != 8'h00) ? rd_reg - 8'h01 : 8'h00;
    rrd_next = (rrd_reg != 8'h00) ? rrd_reg - 8'h01 : 8'h00;
    rfc_next = (rfc_reg != 8'h00) ? rfc_reg - 8'h01 : 8'h00;
    pre_next = (pre_reg != 8'h00) ? pre_reg - 8'h01 : 8'h00;
    axpd_next = (axpd_reg != 8'h00) ? axpd_reg - 8'h01 : 8'h00;
    case (iss_op)
      ddr2_timing_pkg::OP_MRS: begin
        nrd_next = ld(nrd_next, ddr2_timing_pkg::MRD_CYC - 8'h01);
        rd_next = ld(rd_next, ddr2_timing_pkg::MRD_CYC - 8'h01);
      end
      ddr2_timing_pkg::OP_ACT: rrd_next = ddr2_timing_pkg::RRD_CYC - 8'h01;
      ddr2_timing_pkg::OP_RD: pre_next = ld(pre_next, ddr2_timing_pkg::RTP_CYC - 8'h01);
      ddr2_timing_pkg::OP_WR, ddr2_timing_pkg::OP_WRA: begin
        rd_next = ld(rd_next, WR_TO_RD);
        pre_next = ld(pre_next, WR_TO_PRE);
      end
      ddr2_timing_pkg::OP_REF: rfc_next = ddr2_timing_pkg::RFC_CYC - 8'h01;
      ddr2_timing_pkg::OP_SRX: begin
        nrd_next = ddr2_timing_pkg::XSNR_CYC - 8'h01;
        rd_next = ddr2_timing_pkg::XSRD_CYC - 8'h01;
        axpd_next = ddr2_timing_pkg::AXPD_CYC - 8'h01;
      end
      ddr2_timing_pkg::OP_PDX: begin
        nrd_next = ddr2_timing_pkg::XP_CYC - 8'h01;
        rd_next = (pd_act_reg && slow_exit) ? xards - 8'h01
                                            : ddr2_timing_pkg::XARD_CYC - 8'h01;
        axpd_next = ddr2_timing_pkg::AXPD_CYC - 8'h01;
      end
      default: axpd_next = axpd_next;
    endcase
  end

  wire logic cke_sat = (cke_cnt_reg == 8'hff);
  assign cke_cnt_next = (mem_next.cke != mem_reg.cke) ? 8'h00 :
                        cke_sat ? cke_cnt_reg : cke_cnt_reg + 8'h01;
  assign odt_cnt_next = odt_chg ? 8'h00 :
                        (odt_cnt_reg == 8'hff) ? odt_cnt_reg : odt_cnt_reg + 8'h01;
  assign refi_next = (refi_fire || st_reg == ddr2_timing_pkg::ST_SR) ? 8'h00
                                                                      : refi_reg + 8'h01;
  // Clock stops in self refresh only after the hold time, restarts on wake request
  wire logic ck_en_next = !((st_reg == ddr2_timing_pkg::ST_SR)
                            && (cke_cnt_reg >= ddr2_timing_pkg::DLY_CYC)
                            && !(req_valid && req.op == ddr2_timing_pkg::OP_SRX));

  // Pins, mode and counters
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mem_reg <= '{cke: 1'b1, cmd: ddr2_timing_pkg::CMD_NOP, ba: 3'h0, addr: 14'h0000,
                   odt: 1'b0};
      st_reg <= ddr2_timing_pkg::ST_NORM;
      open_reg <= 8'h00;
      lop_reg <= ddr2_timing_pkg::OP_NOP;
    end else begin
      mem_reg <= mem_next;
      st_reg <= st_next;
      open_reg <= open_next;
      lop_reg <= iss_op;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      nrd_reg <= 8'h00;
      rd_reg <= 8'h00;
      rrd_reg <= 8'h00;
      rfc_reg <= 8'h00;
      pre_reg <= 8'h00;
      axpd_reg <= 8'h00;
      cke_cnt_reg <= 8'h00;
      odt_cnt_reg <= 8'h00;
    end else begin
      nrd_reg <= nrd_next;
      rd_reg <= rd_next;
      rrd_reg <= rrd_next;
      rfc_reg <= rfc_next;
      pre_reg <= pre_next;
      axpd_reg <= axpd_next;
      cke_cnt_reg <= cke_cnt_next;
      odt_cnt_reg <= odt_cnt_next;
    end
  end

  // Per-bank reactivation wait after precharge or auto-precharge write
  always_ff @(posedge sys_clk or negedge nrst) begin
    for (int b = 0; b < 8; b++) begin
      if (!nrst) begin
        bank_reg[b] <= 8'h00;
      end else if (iss_op == ddr2_timing_pkg::OP_WRA && req.bank == 3'(b)) begin
        bank_reg[b] <= DAL_LD;
      end else if ((iss_op == ddr2_timing_pkg::OP_PRE && req.bank == 3'(b))
                   || iss_op == ddr2_timing_pkg::OP_PREA) begin
        bank_reg[b] <= ld(bank_reg[b], ddr2_timing_pkg::RP_CYC - 8'h01);
      end else if (bank_reg[b] != 8'h00) begin
        bank_reg[b] <= bank_reg[b] - 8'h01;
      end
    end
  end

  // Refresh timer, pending flag (a new tick wins over the clear) and strobe window
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      refi_reg <= 8'h00;
      ref_pend_reg <= 1'b0;
      pd_act_reg <= 1'b0;
      ck_en_reg <= 1'b1;
      wsh_reg <= '0;
      dqs_en_reg <= 1'b0;
    end else begin
      refi_reg <= refi_next;
      ref_pend_reg <= refi_fire || (ref_pend_reg && iss_op != ddr2_timing_pkg::OP_REF);
      if (iss_op == ddr2_timing_pkg::OP_PDE) pd_act_reg <= !idle;
      ck_en_reg <= ck_en_next;
      wsh_reg <= {wsh_reg[WSH_W-2:0], is_wr};
      dqs_en_reg <= |wsh_reg[WSH_W-1:WL-1];
    end
  end

  assign mem = mem_reg;
  assign ck_en = ck_en_reg;
  assign dqs_en = dqs_en_reg;
  assign dqs_oe_n = !dqs_en_reg;
  assign ref_busy = ref_pend_reg;
  assign mr_wr_cyc = ddr2_timing_pkg::WR_CYC;

  // Checks on the command stream as it leaves for the memory
  logic [7:0] since_srx_reg;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) since_srx_reg <= 8'hff;
    else if (iss_op == ddr2_timing_pkg::OP_SRX) since_srx_reg <= 8'h00;
    else if (since_srx_reg != 8'hff) since_srx_reg <= since_srx_reg + 8'h01;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_mrd;
    lop_reg == ddr2_timing_pkg::OP_MRS |=> lop_reg == ddr2_timing_pkg::OP_NOP;
  endproperty
  a_mrd: assert property (p_mrd) else $error("command too soon after MRS");
  property p_rfc;
    lop_reg == ddr2_timing_pkg::OP_REF |=> (mem.cmd != ddr2_timing_pkg::CMD_ACT
      && mem.cmd != ddr2_timing_pkg::CMD_REF)[*2];
  endproperty
  a_rfc: assert property (p_rfc) else $error("activate or refresh inside tRFC");
  property p_wtr;
    mem.cmd == ddr2_timing_pkg::CMD_WR |=> (mem.cmd != ddr2_timing_pkg::CMD_RD)[*4];
  endproperty
  a_wtr: assert property (p_wtr) else $error("read too soon after write");
  property p_xsrd;
    lop_reg == ddr2_timing_pkg::OP_RD |-> since_srx_reg >= 8'hc9;
  endproperty
  a_xsrd: assert property (p_xsrd) else $error("read too soon after self refresh");
  property p_xp;
    lop_reg == ddr2_timing_pkg::OP_PDX |=> lop_reg == ddr2_timing_pkg::OP_NOP;
  endproperty
  a_xp: assert property (p_xp) else $error("command too soon after power-down exit");
  property p_cke;
    $changed(mem.cke) |=> $stable(mem.cke)[*2];
  endproperty
  a_cke: assert property (p_cke) else $error("clock enable pulse too short");
  property p_anpd;
    lop_reg == ddr2_timing_pkg::OP_PDE |-> $stable(mem.odt)
      && $past(mem.odt) == $past(mem.odt, 2) && $past(mem.odt, 2) == $past(mem.odt, 3);
  endproperty
  a_anpd: assert property (p_anpd) else $error("termination moved before power-down");
  property p_axpd;
    lop_reg == ddr2_timing_pkg::OP_PDX |=> $stable(mem.odt)[*7];
  endproperty
  a_axpd: assert property (p_axpd) else $error("termination moved after exit");
  property p_dqs;
    mem.cmd == ddr2_timing_pkg::CMD_WR |-> ##WL dqs_en && !dqs_oe_n;
  endproperty
  a_dqs: assert property (p_dqs) else $error("write strobe not at write latency");
  property p_ck;
    $fell(mem.cke) |-> ck_en ##1 ck_en;
  endproperty
  a_ck: assert property (p_ck) else $error("clock stopped too soon");
  property p_refi;
    $rose(ref_pend_reg) |-> ##[1:24] lop_reg == ddr2_timing_pkg::OP_REF;
  endproperty
  a_refi: assert property (p_refi) else $error("refresh not issued in time");

  c_sr: cover property (lop_reg == ddr2_timing_pkg::OP_SRE ##[1:300] lop_reg == ddr2_timing_pkg::OP_SRX);
  c_pd: cover property (lop_reg == ddr2_timing_pkg::OP_PDE ##[3:20] lop_reg == ddr2_timing_pkg::OP_PDX);
  c_ref: cover property (lop_reg == ddr2_timing_pkg::OP_PREA ##[1:5] lop_reg == ddr2_timing_pkg::OP_REF);
  c_wra: cover property (lop_reg == ddr2_timing_pkg::OP_WRA ##[1:20] lop_reg == ddr2_timing_pkg::OP_ACT);
endmodule // ddr2_cmd_timer

// >>> ddr2_mem_model.sv
// Device model that counts host spacing faults seen on the DDR2 pins
`timescale 1ns/1ps
module ddr2_mem_model #(
  parameter int WL = 2,
  parameter int BL = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Pins from the host
  input wire ddr2_timing_pkg::pins_s mem,
  input wire logic ck_en,
  input wire logic dqs_en,
  // Faults seen
  output logic [7:0] errs
);
  // Least times in 50 ns cycles, rounded up
  localparam int C75 = (7500 + 49999) / 50000;
  localparam int C15 = (15000 + 49999) / 50000;
  localparam int RFC = (127500 + 49999) / 50000;
  localparam int XSN = (137500 + 49999) / 50000;
  localparam int BE = WL + BL / 2;
  localparam int MR = 0, AC = 1, RF = 2, WR = 3, RD = 4, CK = 5, SR = 6, PD = 7, OD = 8, RI = 9;
  localparam int WA = 10;
  int s [11];
  logic cke_q, odt_q, ck_q, dqs_q, sr_q;
  logic [2:0] wa_ba;
  // Command decode
  wire logic cmd = mem.cke && mem.cmd != 4'h7;
  wire logic [3:0] c = mem.cmd;
  // Spacing faults
  wire logic fault = (cmd && (s[MR] < 2 || s[PD] < 2)) ||
    (cmd && c == 4'h3 && (s[AC] < C75 || s[RF] < RFC || s[SR] < XSN)) ||
    (cmd && c == 4'h3 && mem.ba == wa_ba && s[WA] < BE + 2 * C15) ||
    (cmd && c == 4'h1 && (s[RF] < RFC || s[SR] < XSN)) ||
    (cmd && c == 4'h5 && (s[WR] < BE + C75 || s[SR] < 200)) ||
    (cmd && c == 4'h2 && (s[RD] < C75 || s[WR] < BE + C15)) ||
    (mem.cke != cke_q && s[CK] < 3) ||
    (cke_q && !mem.cke && s[OD] < 3) ||
    (mem.odt != odt_q && (s[PD] < 8 || !mem.cke)) ||
    (dqs_en && !dqs_q && s[WR] != WL) ||
    (ck_q && !ck_en && s[CK] < 2) ||
    (mem.cke && s[RI] > 164);
  // Counters restart at the event they time
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 11; i++) s[i] <= 999;
      s[RI] <= 0; // Refresh interval starts at reset release
      {cke_q, odt_q, ck_q, dqs_q, sr_q} <= 5'h14;
      wa_ba <= 3'h0;
      errs <= 8'h00;
    end else begin
      for (int i = 0; i < 11; i++) s[i] <= s[i] + 1;
      if (cmd && c == 4'h0) s[MR] <= 1;
      if (cmd && c == 4'h3) s[AC] <= 1;
      if (cmd && c == 4'h1) s[RF] <= 1;
      if ((cmd && c == 4'h1) || !mem.cke) s[RI] <= 1;
      if (cmd && c == 4'h4) s[WR] <= 1;
      if (cmd && c == 4'h4 && mem.addr[10]) begin
        s[WA] <= 1;
        wa_ba <= mem.ba;
      end
      if (cmd && c == 4'h5) s[RD] <= 1;
      if (mem.cke != cke_q) s[CK] <= 1;
      if (mem.cke && !cke_q) s[PD] <= 1;
      if (mem.cke && !cke_q && sr_q) s[SR] <= 1;
      if (mem.odt != odt_q) s[OD] <= 1;
      if (!mem.cke && cke_q) sr_q <= c == 4'h1; // Self refresh carries the refresh code
      {cke_q, odt_q, ck_q, dqs_q} <= {mem.cke, mem.odt, ck_en, dqs_en};
      errs <= errs + {7'h00, fault};
    end
  end
endmodule // ddr2_mem_model

// >>> ddr2_cmd_timer_tb.sv
// Bench: requests in, command spacing measured at the pins
`timescale 1ns/1ps
module ddr2_cmd_timer_tb;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  ddr2_timing_pkg::req_s req = '0;
  logic odt_req = 1'b0;
  logic hot_temp = 1'b0;
  logic slow_exit = 1'b0;
  logic fast_grade = 1'b0;
  logic [2:0] add_lat = 3'h3;
  logic req_ready, ref_busy, ck_en, dqs_en, dqs_oe_n;
  logic [7:0] mr_wr_cyc, errs;
  logic [4:0] w, o;
  ddr2_timing_pkg::pins_s mem;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int a, b, c, d;
  // Clock and cycle count
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  ddr2_cmd_timer #(.WL(2), .BL(4)) ddr2_cmd_timer_inst (.sys_clk, .nrst, .req_valid, .req,
    .req_ready, .odt_req, .hot_temp, .slow_exit, .fast_grade, .add_lat, .ref_busy, .mr_wr_cyc,
    .mem, .ck_en, .dqs_en, .dqs_oe_n);
  ddr2_mem_model #(.WL(2), .BL(4)) ddr2_mem_model_inst (.sys_clk, .nrst, .mem, .ck_en, .dqs_en,
    .errs);
  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Present a request until taken; a long wait that runs out is a hang
  task automatic go(input ddr2_timing_pkg::op_e op, input logic [2:0] bk, input int lim,
                    output int at);
    logic took;
    took = 1'b0;
    at = -1;
    if (!req_valid) req_valid <= 1'b1;
    req <= '{op, bk, 14'h0000};
    for (int n = 0; n < lim && !took; n++) begin
      @(negedge sys_clk);
      took = req_ready === 1'b1;
      @(posedge sys_clk);
    end
    if (took) at = cyc;
    else if (lim > 299) begin
      failures++;
      close_out();
    end
  endtask
  task automatic stop();
    req_valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Wait for a refresh on the pins
  task automatic sync(output int at);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (!(mem.cke === 1'b1 && mem.cmd === 4'h1) && n < 400);
    at = cyc;
    if (n == 400) begin
      failures++;
      close_out();
    end
    @(posedge sys_clk);
  endtask
  task automatic t_rows();
    sync(a);
    go(ddr2_timing_pkg::OP_MRS, 3'h0, 300, a);
    go(ddr2_timing_pkg::OP_ACT, 3'h0, 300, b);
    check("mode set gap", b - a, 2);
    go(ddr2_timing_pkg::OP_WR, 3'h0, 300, a);
    fork
      go(ddr2_timing_pkg::OP_RD, 3'h0, 300, b);
      for (int k = 0; k < 5; k++) begin
        @(negedge sys_clk);
        w[k] = dqs_en;
        o[k] = dqs_oe_n;
      end
    join
    check("write to read gap", b - a, 2 + 2 + 1);
    check("strobe window", w, 5'h0c);
    check("strobe drive", o, 5'h13);
    go(ddr2_timing_pkg::OP_PRE, 3'h0, 300, c);
    check("read to precharge gap", c - b, 1);
    go(ddr2_timing_pkg::OP_ACT, 3'h1, 300, a);
    go(ddr2_timing_pkg::OP_ACT, 3'h2, 300, b);
    check("activate gap", b - a, 1);
    go(ddr2_timing_pkg::OP_WRA, 3'h1, 300, a);
    go(ddr2_timing_pkg::OP_ACT, 3'h1, 300, b);
    check("auto precharge gap", b - a, 2 + 2 + 1 + 1);
    go(ddr2_timing_pkg::OP_PREA, 3'h0, 300, a);
    stop();
    $display("test rows done");
  endtask
  task automatic t_refresh();
    sync(a);
    go(ddr2_timing_pkg::OP_REF, 3'h0, 300, a);
    go(ddr2_timing_pkg::OP_REF, 3'h0, 300, b);
    check("refresh gap", b - a, 3);
    stop();
    hot_temp <= 1'b1;
    sync(a);
    sync(a);
    sync(b);
    check("hot interval", b - a <= 3900 / 50 && b - a > 70, 1);
    hot_temp <= 1'b0;
    c = 0;
    while (ref_busy !== 1'b1 && c < 200) begin
      @(negedge sys_clk);
      c++;
    end
    check("busy seen", ref_busy, 1);
    check("busy refuses", req_ready, 0);
    @(negedge sys_clk);
    check("refresh on pins", {ref_busy, mem.cmd}, 5'h01);
    @(posedge sys_clk);
    $display("test refresh done");
  endtask
  task automatic t_pdown();
    sync(a);
    odt_req <= 1'b1;
    @(posedge sys_clk);
    a = cyc;
    go(ddr2_timing_pkg::OP_PDE, 3'h0, 300, b);
    check("odt lead", b - a >= 3, 1);
    odt_req <= 1'b0;
    go(ddr2_timing_pkg::OP_PDX, 3'h0, 300, c);
    check("clock enable hold", c - b, 3);
    go(ddr2_timing_pkg::OP_ACT, 3'h0, 300, d);
    check("power-down exit gap", d - c, 2);
    stop();
    @(negedge sys_clk);
    check("odt frozen", mem.odt, 1);
    repeat (10) @(negedge sys_clk);
    check("odt released", mem.odt, 0);
    @(posedge sys_clk);
    go(ddr2_timing_pkg::OP_PREA, 3'h0, 300, a);
    stop();
    for (int g = 0; g < 2; g++) begin
      slow_exit <= 1'b1;
      fast_grade <= g[0];
      go(ddr2_timing_pkg::OP_ACT, 3'h0, 300, a);
      go(ddr2_timing_pkg::OP_PDE, 3'h0, 300, a);
      go(ddr2_timing_pkg::OP_PDX, 3'h0, 300, b);
      go(ddr2_timing_pkg::OP_RD, 3'h0, 300, c);
      check("slow exit read gap", c - b, (g == 1 ? 8 : 7) - 3);
      go(ddr2_timing_pkg::OP_PRE, 3'h0, 300, a);
      stop();
    end
    $display("test power-down done");
  endtask
  task automatic t_self();
    sync(a);
    go(ddr2_timing_pkg::OP_SRE, 3'h0, 300, a);
    stop();
    @(negedge sys_clk);
    check("clock kept", ck_en, 1);
    repeat (3) @(negedge sys_clk);
    check("clock stopped", ck_en, 0);
    @(posedge sys_clk);
    go(ddr2_timing_pkg::OP_SRX, 3'h0, 300, b);
    go(ddr2_timing_pkg::OP_ACT, 3'h0, 300, c);
    check("self exit gap", c - b, (137500 + 49999) / 50000);
    go(ddr2_timing_pkg::OP_RD, 3'h0, 140, d);
    check("early read refused", d, -1);
    stop();
    $display("test self refresh done");
  endtask
  initial begin
    repeat (11) @(posedge sys_clk);
    @(negedge sys_clk);
    check("idle command", mem.cmd, 4'h7);
    check("reset levels", {mem.cke, ck_en, dqs_oe_n, dqs_en}, 4'he);
    check("recovery count", mr_wr_cyc, (15 + 50 - 1) / 50);
    @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_rows();
    t_refresh();
    t_pdown();
    t_self();
    check("device faults", errs, 0);
    close_out();
  end
endmodule // ddr2_cmd_timer_tb
